// File: include/msw_pkg.sv
package msw_pkg;
  localparam int MODE_W = 5;
  localparam int STATE_W = 4;
  localparam int PROC_W = 3;
  localparam int PAR_W = 8;
  localparam logic [PAR_W-1:0] GLOBAL_IDX = 8'h1C;
  localparam logic [PAR_W-1:0] GLOBAL_SIDX = 8'h02;
  localparam logic [PAR_W-1:0] PTP_IDX = 8'h23;
  localparam logic [PAR_W-1:0] PTP_SIDX = 8'h02;
  localparam logic [PAR_W-1:0] IO_MODE_IDX = 8'h1D;
  localparam logic [PAR_W-1:0] IO_MODE_SIDX = 8'h1F;
  localparam logic [15:0] IO_MODE_RESET = 16'h0000;
  localparam logic [15:0] IO_MODE_FIXED = 16'h0002;
  localparam logic [3:0] ST_START = 4'h1;
  localparam logic [3:0] ST_FAULT = 4'h9;
  localparam int GS_STATE_LSB = 0;
  localparam int GS_RSVD = 4;
  localparam int GS_INT_FLT = 5;
  localparam int GS_EXT_FLT = 6;
  localparam int GS_WARN = 7;
  localparam int GS_PROC_LSB = 13;
  localparam int GS_MODE_LSB = 16;
  localparam int GS_HOMED = 21;
  localparam int GS_STILL = 22;
  localparam int PS_ERR_LO_LSB = 0;
  localparam int PS_ERR_HI_LSB = 5;
  localparam int PS_SETPT = 13;
  localparam int PROC_ADD = 0;
  localparam int PROC_END = 1;
  localparam int PROC_ERR = 2;
  localparam logic [PROC_W-1:0] PROC_RESET = 3'h2;
  localparam logic [31:0] GLOBAL_RESET = 32'h0000_4001;
  localparam logic [15:0] PTP_RESET = 16'h4000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  function automatic logic state_valid(input logic [STATE_W-1:0] code);
    return (code >= ST_START) && (code <= ST_FAULT);
  endfunction
endpackage

// File: include/msw_proc_if.sv
interface msw_proc_if;
  import msw_pkg::*;
  logic [PROC_W-1:0] proc;
  logic [PROC_W-1:0] ptp_proc;
  logic [MODE_W-1:0] mode;
  logic busy;
  modport tracker(output proc, output ptp_proc, output mode, output busy);
  modport viewer(input proc, input ptp_proc, input mode, input busy);
endinterface

// File: design/msw_mode_track.sv
module msw_mode_track #(
  parameter int NUM_MODES = 32,
  parameter logic [msw_pkg::MODE_W-1:0] PTP_MODE = 5'h01
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [msw_pkg::MODE_W-1:0] i_start_mode,
  input wire logic i_done,
  input wire logic i_chain,
  input wire logic [msw_pkg::MODE_W-1:0] i_next_mode,
  input wire logic i_fault,
  input wire logic i_fault_clr,
  input wire logic i_add_info,
  msw_proc_if.tracker o_stat
);
  import msw_pkg::*;
  typedef enum logic {MT_IDLE, MT_RUN} msw_trk_t;
  msw_trk_t st_reg, st_next;
  logic [PROC_W-1:0] stat_reg [NUM_MODES];
  logic [PROC_W-1:0] stat_next [NUM_MODES];
  logic [MODE_W-1:0] act_reg, act_next;
  logic chain_diff;

  assign chain_diff = i_chain && (i_next_mode != act_reg);

  always_comb begin
    stat_next = stat_reg;
    act_next = act_reg;
    st_next = st_reg;
    stat_next[act_reg][PROC_ADD] = i_add_info;
    // Clear first so that a fault in the same cycle wins
    if (i_fault_clr) begin
      stat_next[act_reg][PROC_ERR] = 1'b0;
    end
    case (st_reg)
      MT_IDLE: begin
        // A latched fault blocks any new start
        if (i_start && !stat_reg[act_reg][PROC_ERR]) begin
          act_next = i_start_mode;
          stat_next[i_start_mode][PROC_END] = 1'b0;
          st_next = MT_RUN;
        end
      end
      MT_RUN: begin
        if (i_fault) begin
          stat_next[act_reg][PROC_ERR] = 1'b1;
          stat_next[act_reg][PROC_END] = 1'b1;
          st_next = MT_IDLE;
        end else if (i_done) begin
          if (!chain_diff) begin
            stat_next[act_reg][PROC_END] = 1'b1;
          end
          st_next = MT_IDLE;
        end
      end
      default: begin
        st_next = MT_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg <= MT_IDLE;
      act_reg <= '0;
      for (int i = 0; i < NUM_MODES; i++) begin
        stat_reg[i] <= PROC_RESET;
      end
    end else begin
      st_reg <= st_next;
      act_reg <= act_next;
      stat_reg <= stat_next;
    end
  end

  assign o_stat.proc = stat_reg[act_reg];
  assign o_stat.ptp_proc = stat_reg[PTP_MODE];
  assign o_stat.mode = act_reg;
  assign o_stat.busy = (st_reg == MT_RUN);
endmodule // msw_mode_track

// File: design/msw_par_port.sv
module msw_par_port (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [msw_pkg::PAR_W-1:0] i_idx,
  input wire logic [msw_pkg::PAR_W-1:0] i_sidx,
  input wire logic [31:0] i_wdata,
  input wire logic [31:0] i_global,
  input wire logic [15:0] i_ptp,
  output logic [31:0] o_rdata,
  output logic o_ack,
  output logic o_err,
  output logic [15:0] o_io_mode
);
  import msw_pkg::*;
  logic [31:0] rdata_next;
  logic ack_next, err_next;
  logic [15:0] io_mode_next;
  logic hit_glob, hit_ptp, hit_io;

  always_comb begin
    hit_glob = (i_idx == GLOBAL_IDX) && (i_sidx == GLOBAL_SIDX);
    hit_ptp = (i_idx == PTP_IDX) && (i_sidx == PTP_SIDX);
    hit_io = (i_idx == IO_MODE_IDX) && (i_sidx == IO_MODE_SIDX);
    rdata_next = RDATA_RESET;
    ack_next = i_rd || i_wr;
    err_next = 1'b0;
    io_mode_next = o_io_mode;
    if (i_rd) begin
      if (hit_glob) begin
        rdata_next = i_global;
      end else if (hit_ptp) begin
        rdata_next = {16'h0000, i_ptp};
      end else if (hit_io) begin
        rdata_next = {16'h0000, o_io_mode};
      end else begin
        err_next = 1'b1;
      end
    end else if (i_wr) begin
      // Values above 2 have no meaning and are refused
      if (hit_io && (i_wdata <= {16'h0000, IO_MODE_FIXED})) begin
        io_mode_next = i_wdata[15:0];
      end else begin
        err_next = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= RDATA_RESET;
      o_ack <= 1'b0;
      o_err <= 1'b0;
      o_io_mode <= IO_MODE_RESET;
    end else begin
      o_rdata <= rdata_next;
      o_ack <= ack_next;
      o_err <= err_next;
      o_io_mode <= io_mode_next;
    end
  end
endmodule // msw_par_port

// File: design/msw_status_top.sv
module msw_status_top #(
  parameter int NUM_MODES = 32,
  parameter logic [msw_pkg::MODE_W-1:0] PTP_MODE = 5'h01
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [msw_pkg::STATE_W-1:0] i_drive_state,
  input wire logic i_internal_fault_flag,
  input wire logic i_external_fault_flag,
  input wire logic i_warning,
  input wire logic [msw_pkg::MODE_W-1:0] i_active_mode_number,
  input wire logic i_homed,
  input wire logic i_standstill,
  input wire logic i_pos_limit_error,
  input wire logic i_neg_limit_error,
  input wire logic i_hardware_halt_error,
  input wire logic i_reference_error,
  input wire logic i_soft_pos_limit_error,
  input wire logic i_soft_neg_limit_error,
  input wire logic i_soft_halt_error,
  input wire logic i_setpoint_reached,
  input wire logic i_op_start,
  input wire logic [msw_pkg::MODE_W-1:0] i_op_mode,
  input wire logic i_op_done,
  input wire logic i_op_chain,
  input wire logic [msw_pkg::MODE_W-1:0] i_next_mode,
  input wire logic i_op_fault,
  input wire logic i_fault_clear,
  input wire logic i_add_info,
  input wire logic i_par_rd,
  input wire logic i_par_wr,
  input wire logic [msw_pkg::PAR_W-1:0] i_par_idx,
  input wire logic [msw_pkg::PAR_W-1:0] i_par_sidx,
  input wire logic [31:0] i_par_wdata,
  output logic [31:0] o_par_rdata,
  output logic o_par_ack,
  output logic o_par_err,
  output logic [31:0] o_global_drive_status,
  output logic [15:0] o_point_move_status,
  output logic o_axis_add_info,
  output logic o_axis_end,
  output logic o_axis_err
);
  import msw_pkg::*;
  logic [31:0] glob_reg, glob_next;
  logic [15:0] ptp_reg, ptp_next;
  logic [PROC_W-1:0] axis_reg, axis_next;
  logic [15:0] io_mode;
  logic chain_diff;

  msw_proc_if proc_if();

  msw_mode_track #(
    .NUM_MODES(NUM_MODES),
    .PTP_MODE(PTP_MODE)
  ) u_track (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_start(i_op_start),
    .i_start_mode(i_op_mode),
    .i_done(i_op_done),
    .i_chain(i_op_chain),
    .i_next_mode(i_next_mode),
    .i_fault(i_op_fault),
    .i_fault_clr(i_fault_clear),
    .i_add_info(i_add_info),
    .o_stat(proc_if)
  );

  // Reads see the registered words, so every field of one read is from one cycle
  msw_par_port u_par (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_rd(i_par_rd),
    .i_wr(i_par_wr),
    .i_idx(i_par_idx),
    .i_sidx(i_par_sidx),
    .i_wdata(i_par_wdata),
    .i_global(glob_reg),
    .i_ptp(ptp_reg),
    .o_rdata(o_par_rdata),
    .o_ack(o_par_ack),
    .o_err(o_par_err),
    .o_io_mode(io_mode)
  );

  assign chain_diff = i_op_chain && (i_next_mode != proc_if.mode);

  always_comb begin
    glob_next = 32'h0000_0000;
    // An out-of-range code is a transient upstream; keep the last good one
    if (state_valid(i_drive_state)) begin
      glob_next[GS_STATE_LSB +: STATE_W] = i_drive_state;
    end else begin
      glob_next[GS_STATE_LSB +: STATE_W] = glob_reg[GS_STATE_LSB +: STATE_W];
    end
    glob_next[GS_RSVD] = 1'b0;
    glob_next[GS_INT_FLT] = i_internal_fault_flag;
    glob_next[GS_EXT_FLT] = i_external_fault_flag;
    glob_next[GS_WARN] = i_warning;
    glob_next[GS_PROC_LSB +: PROC_W] = proc_if.proc;
    glob_next[GS_MODE_LSB +: MODE_W] = i_active_mode_number;
    glob_next[GS_HOMED] = i_homed;
    glob_next[GS_STILL] = i_standstill;
    ptp_next = 16'h0000;
    ptp_next[PS_ERR_LO_LSB +: 4] = {i_reference_error, i_hardware_halt_error,
                                    i_neg_limit_error, i_pos_limit_error};
    ptp_next[PS_ERR_HI_LSB +: 3] = {i_soft_halt_error, i_soft_neg_limit_error,
                                    i_soft_pos_limit_error};
    ptp_next[PS_SETPT] = i_setpoint_reached;
    ptp_next[GS_PROC_LSB + PROC_END] = proc_if.ptp_proc[PROC_END];
    ptp_next[GS_PROC_LSB + PROC_ERR] = proc_if.ptp_proc[PROC_ERR];
    // Outputs stay low unless the I/O is given its fixed functions
    if (io_mode == IO_MODE_FIXED) begin
      axis_next = proc_if.proc;
    end else begin
      axis_next = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      glob_reg <= GLOBAL_RESET;
      ptp_reg <= PTP_RESET;
      axis_reg <= '0;
    end else begin
      glob_reg <= glob_next;
      ptp_reg <= ptp_next;
      axis_reg <= axis_next;
    end
  end

  assign o_global_drive_status = glob_reg;
  assign o_point_move_status = ptp_reg;
  assign o_axis_add_info = axis_reg[PROC_ADD];
  assign o_axis_end = axis_reg[PROC_END];
  assign o_axis_err = axis_reg[PROC_ERR];

  a_state_copy: assert property (@(posedge i_clk) disable iff (i_rst)
    !$past(i_rst) && state_valid($past(i_drive_state))
    |-> glob_reg[3:0] == $past(i_drive_state))
    else $error("state field does not follow drive state");

  a_state_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    !$past(i_rst) && !state_valid($past(i_drive_state))
    |-> $stable(glob_reg[3:0]))
    else $error("invalid state code was not held off");

  a_flag_bits: assert property (@(posedge i_clk) disable iff (i_rst)
    !$past(i_rst) |-> !glob_reg[4]
      && glob_reg[5] == $past(i_internal_fault_flag)
      && glob_reg[6] == $past(i_external_fault_flag)
      && glob_reg[7] == $past(i_warning))
    else $error("fault or warning bits wrong");

  a_mode_homed: assert property (@(posedge i_clk) disable iff (i_rst)
    !$past(i_rst) |-> glob_reg[20:16] == $past(i_active_mode_number)
      && glob_reg[21] == $past(i_homed))
    else $error("mode number or homed bit wrong");

  a_still_bit: assert property (@(posedge i_clk) disable iff (i_rst)
    !$past(i_rst) |-> glob_reg[22] == $past(i_standstill))
    else $error("standstill bit wrong");

  a_proc_copy: assert property (@(posedge i_clk) disable iff (i_rst)
    !$past(i_rst) |-> glob_reg[15:13] == $past(proc_if.proc))
    else $error("processing bits not copied from active mode");

  a_end_drop: assert property (@(posedge i_clk) disable iff (i_rst)
    i_op_start && !proc_if.busy && !proc_if.proc[PROC_ERR]
    |=> !proc_if.proc[PROC_END] ##1 !glob_reg[14])
    else $error("start did not clear finished bit");

  a_end_rise: assert property (@(posedge i_clk) disable iff (i_rst)
    proc_if.busy && i_op_done && !chain_diff
    |=> proc_if.proc[PROC_END] ##1 glob_reg[14])
    else $error("completion did not set finished bit");

  a_chain_low: assert property (@(posedge i_clk) disable iff (i_rst)
    proc_if.busy && i_op_done && chain_diff && !i_op_fault
    |=> !proc_if.proc[PROC_END] ##1 !glob_reg[14])
    else $error("chained completion raised finished bit");

  a_fault_set: assert property (@(posedge i_clk) disable iff (i_rst)
    proc_if.busy && i_op_fault |=> proc_if.proc[PROC_ERR] ##1 glob_reg[15])
    else $error("fault did not set error bit");

  a_fault_block: assert property (@(posedge i_clk) disable iff (i_rst)
    proc_if.proc[PROC_ERR] && !proc_if.busy |=> !proc_if.busy)
    else $error("start accepted while fault pending");

  a_axis_fixed: assert property (@(posedge i_clk) disable iff (i_rst)
    !$past(i_rst) |-> o_axis_end == ($past(io_mode) == IO_MODE_FIXED
      && $past(proc_if.proc[PROC_END]))
      && o_axis_err == ($past(io_mode) == IO_MODE_FIXED
      && $past(proc_if.proc[PROC_ERR])))
    else $error("axis outputs do not mirror status in fixed I/O");

  a_ro_write: assert property (@(posedge i_clk) disable iff (i_rst)
    i_par_wr && !i_par_rd && i_par_idx == GLOBAL_IDX && i_par_sidx == GLOBAL_SIDX
    |=> o_par_ack && o_par_err)
    else $error("write to status word not refused");

  a_ptp_bits: assert property (@(posedge i_clk) disable iff (i_rst)
    !$past(i_rst) |-> ptp_reg[0] == $past(i_pos_limit_error)
      && ptp_reg[7] == $past(i_soft_halt_error) && !ptp_reg[4]
      && ptp_reg[13] == $past(i_setpoint_reached)
      && ptp_reg[14] == $past(proc_if.ptp_proc[PROC_END]))
    else $error("point move status bits wrong");
endmodule // msw_status_top

// File: dv/msw_bus_model.sv
module msw_bus_model (
  input wire logic i_clk,
  input wire logic i_ack,
  output logic o_rd,
  output logic o_wr,
  output logic [7:0] o_idx,
  output logic [7:0] o_sidx,
  output logic [31:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_idx = 8'h00;
    o_sidx = 8'h00;
    o_wdata = 32'h0000_0000;
  end

  // One-cycle request pulse, then a bounded wait for the answer
  task automatic access(input logic rd, input logic [7:0] idx, input logic [7:0] sidx,
                        input logic [31:0] wd);
    int n;
    @(posedge i_clk);
    o_rd <= rd;
    o_wr <= ~rd;
    o_idx <= idx;
    o_sidx <= sidx;
    o_wdata <= wd;
    @(posedge i_clk);
    // Strobes drop to 0; index and data lines carry the inverse so a stale value never passes as live
    o_rd <= 1'b0;
    o_wr <= 1'b0;
    o_idx <= ~idx;
    o_sidx <= ~sidx;
    o_wdata <= ~wd;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_ack !== 1'b1 && n < 4);
  endtask
endmodule // msw_bus_model

// File: dv/motion_status_word_logic_bench.sv
module motion_status_word_logic_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import msw_pkg::*;

  typedef struct packed {logic [31:0] d; logic e;} msw_exp_t;

  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [3:0] st = 4'h1;
  logic [3:0] last_st;
  logic [2:0] flt = 3'h0;
  logic [4:0] amode = 5'h00;
  logic homed = 1'b0;
  logic still = 1'b0;
  logic [7:0] perr = 8'h00;
  logic setpt = 1'b0;
  logic [4:0] pulses = 5'h00;
  logic [4:0] op_mode = 5'h00;
  logic [4:0] next_mode = 5'h00;
  logic add_info = 1'b0;
  logic rd, wr, ack, err, ax_add, ax_end, ax_err;
  logic [7:0] idx, sidx;
  logic [31:0] wdata, rdata, gword;
  logic [15:0] pword;
  logic [2:0] axis;
  msw_exp_t exp_q[$];
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  int seed = 31;
  int i;

  assign axis = {ax_err, ax_end, ax_add};

  always #2.5 i_clk = ~i_clk;

  msw_bus_model bus_u (.i_clk(i_clk), .i_ack(ack), .o_rd(rd), .o_wr(wr), .o_idx(idx),
    .o_sidx(sidx), .o_wdata(wdata));

  msw_status_top dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_drive_state(st),
    .i_internal_fault_flag(flt[0]), .i_external_fault_flag(flt[1]), .i_warning(flt[2]),
    .i_active_mode_number(amode), .i_homed(homed), .i_standstill(still),
    .i_pos_limit_error(perr[0]), .i_neg_limit_error(perr[1]),
    .i_hardware_halt_error(perr[2]), .i_reference_error(perr[3]),
    .i_soft_pos_limit_error(perr[5]), .i_soft_neg_limit_error(perr[6]),
    .i_soft_halt_error(perr[7]), .i_setpoint_reached(setpt), .i_op_start(pulses[4]),
    .i_op_mode(op_mode), .i_op_done(pulses[3]), .i_op_chain(pulses[2]),
    .i_next_mode(next_mode), .i_op_fault(pulses[1]), .i_fault_clear(pulses[0]),
    .i_add_info(add_info), .i_par_rd(rd), .i_par_wr(wr), .i_par_idx(idx),
    .i_par_sidx(sidx), .i_par_wdata(wdata), .o_par_rdata(rdata), .o_par_ack(ack),
    .o_par_err(err), .o_global_drive_status(gword), .o_point_move_status(pword),
    .o_axis_add_info(ax_add), .o_axis_end(ax_end), .o_axis_err(ax_err));

  function automatic logic [31:0] gw(input logic [3:0] s, input logic [2:0] proc);
    return {9'h000, still, homed, amode, proc, 5'h00, flt, 1'b0, s};
  endfunction

  function automatic logic [31:0] pw();
    return {16'h0000, 3'b010 | {2'b00, setpt}, 5'h00, perr[7:5], 1'b0, perr[3:0]};
  endfunction

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_bus(input msw_exp_t got, input msw_exp_t exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] x, input logic [7:0] s, input logic [31:0] d,
                        input logic e);
    exp_q.push_back({d, e});
    bus_u.access(1'b1, x, s, 32'h0000_0000);
  endtask

  task automatic wr_chk(input logic [7:0] x, input logic [7:0] s, input logic [31:0] d,
                        input logic e);
    exp_q.push_back({32'h0000_0000, e});
    bus_u.access(1'b0, x, s, d);
  endtask

  // Processing bits show two cycles after the pulse; wait two more for margin
  task automatic op(input logic [4:0] p, input logic [2:0] proc);
    @(posedge i_clk);
    pulses <= p;
    @(posedge i_clk);
    pulses <= 5'h00;
    repeat (3) @(posedge i_clk);
    #1;
    cmp_word({29'h0, gword[15:13]}, {29'h0, proc});
    cmp_word({29'h0, axis}, {29'h0, proc});
  endtask

  task automatic end_sim;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    if (ack === 1'b1) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, rdata, 32'h0);
      end else begin
        cmp_bus({rdata, err}, exp_q.pop_front());
      end
    end
  end

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      end_sim();
    end
  end

  initial begin
    repeat (2) @(posedge i_clk);
    #1;
    cmp_word(gword, GLOBAL_RESET);
    cmp_word({16'h0000, pword}, {16'h0000, PTP_RESET});
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    for (i = 0; i < 8; i++) begin
      @(posedge i_clk);
      st <= 4'(($unsigned($random(seed)) % 9) + 1);
      {flt, homed, still, setpt} <= 6'($random(seed));
      amode <= 5'($random(seed));
      perr <= 8'($random(seed)) & 8'hEF;
      repeat (3) @(posedge i_clk);
      rd_chk(GLOBAL_IDX, GLOBAL_SIDX, gw(st, 3'h2), 1'b0);
      rd_chk(PTP_IDX, PTP_SIDX, pw(), 1'b0);
      cmp_word({29'h0, axis}, 32'h0);
    end
    // Out-of-range state codes must not disturb the field
    last_st = st;
    @(posedge i_clk);
    st <= 4'hC;
    repeat (3) @(posedge i_clk);
    rd_chk(GLOBAL_IDX, GLOBAL_SIDX, gw(last_st, 3'h2), 1'b0);
    wr_chk(GLOBAL_IDX, GLOBAL_SIDX, 32'($random(seed)), 1'b1);
    wr_chk(PTP_IDX, PTP_SIDX, 32'($random(seed)), 1'b1);
    rd_chk(GLOBAL_IDX, GLOBAL_SIDX, gw(last_st, 3'h2), 1'b0);
    rd_chk(PTP_IDX, PTP_SIDX, pw(), 1'b0);
    rd_chk(8'h00, 8'h00, 32'h0000_0000, 1'b1);
    // Ends on the refused value 3, so the fixed setting 2 stays in force
    for (i = 0; i < 4; i++) begin
      wr_chk(IO_MODE_IDX, IO_MODE_SIDX, 32'(i), i > 2);
      rd_chk(IO_MODE_IDX, IO_MODE_SIDX, (i > 2) ? 32'h2 : 32'(i), 1'b0);
      repeat (2) @(posedge i_clk);
      #1;
      cmp_word({29'h0, axis}, (i >= 2) ? 32'h2 : 32'h0);
    end
    @(posedge i_clk);
    amode <= 5'h03;
    op_mode <= 5'h03;
    next_mode <= 5'h04;
    add_info <= 1'b1;
    op(5'b10000, 3'b001);
    op(5'b01000, 3'b011);
    op(5'b10000, 3'b001);
    op(5'b01100, 3'b001);
    @(posedge i_clk);
    amode <= 5'h04;
    op_mode <= 5'h04;
    // A chained completion leaves the tracker idle; the next mode needs its own start
    op(5'b10000, 3'b001);
    op(5'b00010, 3'b111);
    op(5'b10000, 3'b111);
    op(5'b00001, 3'b011);
    op(5'b10000, 3'b001);
    op(5'b01000, 3'b011);
    rd_chk(GLOBAL_IDX, GLOBAL_SIDX, gw(last_st, 3'b011), 1'b0);
    repeat (3) @(posedge i_clk);
    end_sim();
  end
endmodule // motion_status_word_logic_bench
